// ===== verilog/sfoc_pkg.sv
package sfoc_pkg;
  // instruction codes
  localparam logic [7:0] OP_ID1 = 8'h90;
  localparam logic [7:0] OP_ID2 = 8'h92;
  localparam logic [7:0] OP_ID4 = 8'h94;
  localparam logic [7:0] OP_UID = 8'h4b;
  localparam logic [7:0] OP_JID = 8'h9f;
  localparam logic [7:0] OP_SFDP = 8'h5a;
  localparam logic [7:0] OP_ERASE = 8'h44;
  localparam logic [7:0] OP_PROG = 8'h42;
  // lane counts per clock
  localparam logic [2:0] LN1 = 3'h1;
  localparam logic [2:0] LN2 = 3'h2;
  localparam logic [2:0] LN4 = 3'h4;
  // address field lengths in bits, dummy lengths in clocks
  localparam logic [5:0] ALEN_NONE = 6'h00;
  localparam logic [5:0] ALEN_24 = 6'h18;
  localparam logic [5:0] ALEN_32 = 6'h20;
  localparam logic [3:0] DUM_NONE = 4'h0;
  localparam logic [3:0] DUM_QUAD = 4'h4;
  localparam logic [3:0] DUM_SFDP = 4'h8;
  // continuation-mode pattern sent by the host
  localparam logic [7:0] CONT_MODE_VAL = 8'hf0;
  localparam logic [7:0] UID_DUMMY_VAL = 8'h00;
  // security areas
  localparam logic [3:0] AREA_FIRST = 4'h1;
  localparam logic [3:0] AREA_LAST = 4'h3;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  localparam logic [7:0] OTP_LAST = 8'hff;
  localparam logic [31:0] TBL_SIGNATURE = 32'h5346_4450;
  localparam logic [7:0] TBL_SIG_BYTES = 8'h04;
  // byte framing
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [11:0] CMD_CLOCKS = 12'h008;
  // output enables by lane count
  localparam logic [3:0] OE_SI = 4'h1;
  localparam logic [3:0] OE_SO = 4'h2;
  localparam logic [3:0] OE_DUAL = 4'h3;
  localparam logic [3:0] OE_QUAD = 4'hf;
  // host serial clock: last count of a half period, which lasts two system cycles
  localparam logic [1:0] HALF_LAST = 2'h1;

  function automatic logic [2:0] sfoc_lanes(input logic [7:0] op);
    sfoc_lanes = (op == OP_ID4) ? LN4 : ((op == OP_ID2) ? LN2 : LN1);
  endfunction

  function automatic logic [5:0] sfoc_addr_len(input logic [7:0] op);
    case (op)
      OP_ID2, OP_ID4, OP_UID: sfoc_addr_len = ALEN_32;
      OP_ID1, OP_SFDP, OP_ERASE, OP_PROG: sfoc_addr_len = ALEN_24;
      default: sfoc_addr_len = ALEN_NONE;
    endcase
  endfunction

  function automatic logic [3:0] sfoc_dummy(input logic [7:0] op);
    sfoc_dummy = (op == OP_ID4) ? DUM_QUAD : ((op == OP_SFDP) ? DUM_SFDP : DUM_NONE);
  endfunction
endpackage

// ===== verilog/sfoc_spi_if.sv
`timescale 1ns/1ps
interface sfoc_spi_if;
  logic cs_n;
  logic sclk;
  logic [3:0] h_out;
  logic [3:0] h_oe;
  logic [3:0] d_out;
  logic [3:0] d_oe;
  logic [3:0] io;

  // line level: device drive first, then host, else pulled high
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      io[i] = d_oe[i] ? d_out[i] : (h_oe[i] ? h_out[i] : 1'b1);
    end
  end

  modport dev (input cs_n, input sclk, input io, output d_out, output d_oe);
  modport host (output cs_n, output sclk, output h_out, output h_oe, input io);
endinterface

// ===== verilog/sfoc_flash_dev.sv
`timescale 1ns/1ps
module sfoc_flash_dev
  import sfoc_pkg::*;
#(
  parameter logic [7:0] MANUF_ID = 8'h5c, // arbitrary value
  parameter logic [7:0] DEVICE_ID = 8'h14, // arbitrary value
  parameter logic [7:0] MEM_TYPE = 8'h40, // arbitrary value
  parameter logic [7:0] CAPACITY = 8'h15, // arbitrary value
  parameter logic [63:0] UNIQUE_ID = 64'h0123_4567_89ab_cdef // arbitrary value
) (
  input wire logic clock,
  input wire logic reset,
  sfoc_spi_if.dev spi,
  input wire logic wel_set,
  input wire logic [3:1] lock_set,
  output logic busy,
  output logic write_enable_latch,
  output logic [3:1] area_lock_bits
);
  typedef enum logic [6:0] {
    D_CMD = 7'h01,
    D_ADDR = 7'h02,
    D_DUMMY = 7'h04,
    D_OUT = 7'h08,
    D_PROG = 7'h10,
    D_HOLD = 7'h20,
    D_SKIP = 7'h40
  } sfoc_dstate_t;

  sfoc_dstate_t st_q, st_d;
  logic csn_q, sclk_q;
  logic [7:0] op_q, op_d;
  logic [31:0] sh_q, sh_d;
  logic [5:0] cnt_q, cnt_d;
  logic [2:0] ln_q, ln_d;
  logic [23:0] addr_q, addr_d;
  logic [7:0] idx_q, idx_d, ob_q, ob_d;
  logic [3:0] rem_q, rem_d, dout_q, dout_d, oe_q, oe_d;
  logic prog_any_q, prog_any_d;
  logic [1:0] aidx_q, aidx_d;
  logic busy_q, erasing_q, wel_q;
  logic [7:0] walk_q;
  logic [3:1] lock_q;
  logic [7:0] cur_b;
  logic [7:0] otp_mem [0:767];

  function automatic logic [3:0] lane_top(input logic [7:0] b, input logic [2:0] l);
    if (l == LN4) begin
      lane_top = b[7:4];
    end else if (l == LN2) begin
      lane_top = {2'h0, b[7:6]};
    end else begin
      lane_top = {2'h0, b[7], 1'b0};
    end
  endfunction

  function automatic logic [7:0] tbl_byte(input logic [7:0] a);
    if (a < TBL_SIG_BYTES) begin
      tbl_byte = TBL_SIGNATURE[8 * (3 - a[1:0]) +: 8];
    end else begin
      tbl_byte = ERASED_BYTE;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // edge detection and input decode
  wire sel = ~spi.cs_n;
  wire rise = sel & spi.sclk & ~sclk_q;
  wire fall = sel & ~spi.sclk & sclk_q;
  wire cs_end = spi.cs_n & ~csn_q;
  wire [31:0] sh_in = (ln_q == LN4) ? {sh_q[27:0], spi.io} :
                      (ln_q == LN2) ? {sh_q[29:0], spi.io[1:0]} : {sh_q[30:0], spi.io[0]};
  wire [5:0] cnt_inc = cnt_q + {3'h0, ln_q};
  wire [5:0] alen = sfoc_addr_len(op_q);
  wire [23:0] addr_in = (alen == ALEN_32) ? sh_in[31:8] : sh_in[23:0];
  wire [3:0] area = addr_in[15:12];
  wire area_ok = (addr_in[23:16] == 8'h00) && (area >= AREA_FIRST) && (area <= AREA_LAST);
  wire [3:0] lock_vec = {lock_q, 1'b0};
  wire wr_ok = wel_q & area_ok & ~lock_vec[area[1:0]];
  wire byte_done = (cnt_q[2:0] == BIT_LAST);
  wire prog_wr = (st_q == D_PROG) & rise & byte_done;
  wire start_op = cs_end & ((st_q == D_HOLD) | ((st_q == D_PROG) & prog_any_q));
  wire walk_end = busy_q & (walk_q == OTP_LAST);
  wire [3:0] oe_mask = (ln_q == LN4) ? OE_QUAD : ((ln_q == LN2) ? OE_DUAL : OE_SO);

  // byte source for the read-out phase
  always_comb begin
    case (op_q)
      OP_ID1, OP_ID2, OP_ID4: cur_b = (idx_q[0] ^ addr_q[0]) ? DEVICE_ID : MANUF_ID;
      OP_UID: cur_b = UNIQUE_ID[8 * (7 - idx_q[2:0]) +: 8];
      OP_JID: cur_b = (idx_q == 8'h00) ? MANUF_ID : (idx_q == 8'h01) ? MEM_TYPE :
                      (idx_q == 8'h02) ? CAPACITY : 8'h00;
      OP_SFDP: cur_b = tbl_byte(addr_q[7:0] + idx_q);
      default: cur_b = ERASED_BYTE;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // instruction sequencer
  always_comb begin
    st_d = st_q;
    op_d = op_q;
    sh_d = sh_q;
    cnt_d = cnt_q;
    ln_d = ln_q;
    addr_d = addr_q;
    idx_d = idx_q;
    ob_d = ob_q;
    rem_d = rem_q;
    dout_d = dout_q;
    oe_d = oe_q;
    prog_any_d = prog_any_q;
    aidx_d = aidx_q;
    if (!sel) begin
      st_d = D_CMD;
      sh_d = '0;
      cnt_d = '0;
      ln_d = LN1;
      idx_d = '0;
      rem_d = '0;
      oe_d = '0;
      prog_any_d = 1'b0;
    end else begin
      case (st_q)
        D_CMD: if (rise) begin
          sh_d = sh_in;
          cnt_d = cnt_inc;
          if (cnt_q[2:0] == BIT_LAST) begin
            op_d = sh_in[7:0];
            cnt_d = '0;
            sh_d = '0;
            ln_d = sfoc_lanes(sh_in[7:0]);
            if (busy_q) begin
              st_d = D_SKIP;
            end else if (sh_in[7:0] == OP_JID) begin
              st_d = D_OUT;
            end else if (sfoc_addr_len(sh_in[7:0]) != ALEN_NONE) begin
              st_d = D_ADDR;
            end else begin
              st_d = D_SKIP;
            end
          end
        end
        D_ADDR: if (rise) begin
          sh_d = sh_in;
          cnt_d = cnt_inc;
          if (cnt_inc == alen) begin
            addr_d = addr_in;
            cnt_d = '0;
            aidx_d = area[1:0] - 2'h1;
            if (op_q == OP_ERASE) begin
              st_d = wr_ok ? D_HOLD : D_SKIP;
            end else if (op_q == OP_PROG) begin
              st_d = wr_ok ? D_PROG : D_SKIP;
            end else if ((op_q == OP_SFDP) && (addr_in[23:8] != 16'h0000)) begin
              st_d = D_SKIP;
            end else if (sfoc_dummy(op_q) != DUM_NONE) begin
              st_d = D_DUMMY;
            end else begin
              st_d = D_OUT;
            end
          end
        end
        D_DUMMY: if (rise) begin
          cnt_d = cnt_q + 6'h01;
          if (cnt_q[3:0] + 4'h1 == sfoc_dummy(op_q)) begin
            cnt_d = '0;
            st_d = D_OUT;
          end
        end
        D_OUT: if (fall) begin
          oe_d = oe_mask;
          if (rem_q == 4'h0) begin
            dout_d = lane_top(cur_b, ln_q);
            ob_d = cur_b << ln_q;
            rem_d = BYTE_BITS - {1'b0, ln_q};
            idx_d = idx_q + 8'h01;
          end else begin
            dout_d = lane_top(ob_q, ln_q);
            ob_d = ob_q << ln_q;
            rem_d = rem_q - {1'b0, ln_q};
          end
        end
        D_PROG: if (rise) begin
          sh_d = sh_in;
          cnt_d = cnt_inc;
          if (byte_done) begin
            cnt_d = '0;
            prog_any_d = 1'b1;
            addr_d[7:0] = addr_q[7:0] + 8'h01;
          end
        end
        D_HOLD: if (rise) begin
          st_d = D_SKIP;
        end
        D_SKIP: st_d = D_SKIP;
        default: st_d = D_SKIP;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      st_q <= D_CMD;
      csn_q <= 1'b1;
      sclk_q <= 1'b0;
      op_q <= '0;
      sh_q <= '0;
      cnt_q <= '0;
      ln_q <= LN1;
      addr_q <= '0;
      idx_q <= '0;
      ob_q <= '0;
      rem_q <= '0;
      dout_q <= '0;
      oe_q <= '0;
      prog_any_q <= 1'b0;
      aidx_q <= '0;
    end else begin
      st_q <= st_d;
      csn_q <= spi.cs_n;
      sclk_q <= spi.sclk;
      op_q <= op_d;
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      ln_q <= ln_d;
      addr_q <= addr_d;
      idx_q <= idx_d;
      ob_q <= ob_d;
      rem_q <= rem_d;
      dout_q <= dout_d;
      oe_q <= oe_d;
      prog_any_q <= prog_any_d;
      aidx_q <= aidx_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // self-timed erase / program engine and status
  always_ff @(posedge clock) begin
    if (reset) begin
      busy_q <= 1'b0;
      erasing_q <= 1'b0;
      walk_q <= '0;
    end else if (start_op) begin
      busy_q <= 1'b1;
      erasing_q <= (op_q == OP_ERASE);
      walk_q <= '0;
    end else if (busy_q) begin
      walk_q <= walk_q + 8'h01;
      busy_q <= ~walk_end;
    end
  end

  // set from outside wins over the clear at cycle end
  always_ff @(posedge clock) begin
    if (reset) begin
      wel_q <= 1'b0;
      lock_q <= '0;
    end else begin
      wel_q <= wel_set | (wel_q & ~walk_end);
      lock_q <= lock_q | lock_set;
    end
  end

  // security area storage: erase walks every byte, program only clears bits
  always_ff @(posedge clock) begin
    if (busy_q & erasing_q) begin
      otp_mem[{aidx_q, walk_q}] <= ERASED_BYTE;
    end else if (prog_wr) begin
      otp_mem[{aidx_q, addr_q[7:0]}] <= otp_mem[{aidx_q, addr_q[7:0]}] & sh_in[7:0];
    end
  end

  assign spi.d_out = dout_q;
  assign spi.d_oe = oe_q;
  assign busy = busy_q;
  assign write_enable_latch = wel_q;
  assign area_lock_bits = lock_q;
endmodule

// ===== verilog/sfoc_spi_host.sv
`timescale 1ns/1ps
module sfoc_spi_host
  import sfoc_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  sfoc_spi_if.host spi,
  input wire logic start,
  input wire logic [7:0] opcode,
  input wire logic [23:0] address,
  input wire logic [8:0] write_count,
  input wire logic [8:0] read_count,
  input wire logic [7:0] tx_byte,
  output logic tx_take,
  output logic [7:0] rx_byte,
  output logic rx_valid,
  output logic ready
);
  typedef enum logic [6:0] {
    H_IDLE = 7'h01,
    H_CMD = 7'h02,
    H_ADDR = 7'h04,
    H_DUMMY = 7'h08,
    H_WR = 7'h10,
    H_RD = 7'h20,
    H_GAP = 7'h40
  } sfoc_hstate_t;

  sfoc_hstate_t st_q, st_d, nx;
  logic [7:0] op_q, op_d;
  logic [23:0] addr_q, addr_d;
  logic [8:0] wcnt_q, wcnt_d, rcnt_q, rcnt_d;
  logic [31:0] sh_q, sh_d;
  logic [2:0] ln_q, ln_d;
  logic [11:0] cnt_q, cnt_d;
  logic [1:0] half_q, half_d;
  logic sclk_q, sclk_d, csn_q, csn_d;
  logic [7:0] rx_sh_q, rx_sh_d, rx_byte_q, rx_byte_d;
  logic [3:0] rbits_q, rbits_d;
  logic rx_valid_q, rx_valid_d, tx_take_q, tx_take_d;

  function automatic logic [11:0] clocks_for(input logic [11:0] bits, input logic [2:0] l);
    clocks_for = (l == LN4) ? (bits >> 2) : ((l == LN2) ? (bits >> 1) : bits);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // decode
  wire [5:0] alen = sfoc_addr_len(op_q);
  wire [3:0] dum = sfoc_dummy(op_q);
  wire [2:0] op_ln = sfoc_lanes(op_q);
  wire tick = (st_q != H_IDLE) && (half_q == HALF_LAST);
  wire running = (st_q != H_IDLE) && (st_q != H_GAP);
  wire rising = tick & running & ~sclk_q;
  wire falling = tick & running & sclk_q;
  wire drive = (st_q == H_CMD) || (st_q == H_ADDR) || (st_q == H_WR);
  wire [3:0] oe_mask = (ln_q == LN4) ? OE_QUAD : ((ln_q == LN2) ? OE_DUAL : OE_SI);
  wire [7:0] addr_tail = (op_q == OP_UID) ? UID_DUMMY_VAL : CONT_MODE_VAL;
  wire [7:0] rx_in = (ln_q == LN4) ? {rx_sh_q[3:0], spi.io} :
                     (ln_q == LN2) ? {rx_sh_q[5:0], spi.io[1:0]} : {rx_sh_q[6:0], spi.io[1]};
  wire [3:0] rbits_inc = rbits_q + {1'b0, ln_q};

  // phase that follows the current one
  always_comb begin
    case (st_q)
      H_CMD: nx = (alen != ALEN_NONE) ? H_ADDR : ((rcnt_q != 9'h000) ? H_RD : H_GAP);
      H_ADDR: nx = (dum != DUM_NONE) ? H_DUMMY : (wcnt_q != 9'h000) ? H_WR :
                   (rcnt_q != 9'h000) ? H_RD : H_GAP;
      H_DUMMY, H_WR: nx = (rcnt_q != 9'h000) ? H_RD : H_GAP;
      default: nx = H_GAP;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame sequencer
  always_comb begin
    st_d = st_q;
    op_d = op_q;
    addr_d = addr_q;
    wcnt_d = wcnt_q;
    rcnt_d = rcnt_q;
    sh_d = sh_q;
    ln_d = ln_q;
    cnt_d = cnt_q;
    half_d = tick ? 2'h0 : half_q + 2'h1;
    sclk_d = sclk_q;
    csn_d = csn_q;
    rx_sh_d = rx_sh_q;
    rx_byte_d = rx_byte_q;
    rbits_d = rbits_q;
    rx_valid_d = 1'b0;
    tx_take_d = 1'b0;
    case (st_q)
      H_IDLE: begin
        half_d = 2'h0;
        if (start) begin
          st_d = H_CMD;
          op_d = opcode;
          addr_d = address;
          wcnt_d = write_count;
          rcnt_d = read_count;
          sh_d = {opcode, 24'h000000};
          ln_d = LN1;
          cnt_d = CMD_CLOCKS;
          csn_d = 1'b0;
          rbits_d = '0;
        end
      end
      H_GAP: if (tick) begin
        st_d = H_IDLE;
      end
      default: begin
        if (rising) begin
          sclk_d = 1'b1;
          if (st_q == H_RD) begin
            rx_sh_d = rx_in;
            rbits_d = rbits_inc;
            if (rbits_inc == BYTE_BITS) begin
              rx_byte_d = rx_in;
              rx_valid_d = 1'b1;
              rbits_d = '0;
            end
          end
        end
        if (falling) begin
          sclk_d = 1'b0;
          if (cnt_q == 12'h001) begin
            st_d = nx;
            case (nx)
              H_ADDR: begin
                sh_d = (alen == ALEN_32) ? {addr_q, addr_tail} : {addr_q, 8'h00};
                ln_d = op_ln;
                cnt_d = clocks_for({6'h00, alen}, op_ln);
              end
              H_DUMMY: cnt_d = {8'h00, dum};
              H_WR: begin
                sh_d = {tx_byte, 24'h000000};
                ln_d = LN1;
                tx_take_d = 1'b1;
                cnt_d = {wcnt_q, 3'h0};
              end
              H_RD: begin
                ln_d = op_ln;
                cnt_d = clocks_for({rcnt_q, 3'h0}, op_ln);
              end
              default: csn_d = 1'b1;
            endcase
          end else begin
            cnt_d = cnt_q - 12'h001;
            sh_d = sh_q << ln_q;
            if ((st_q == H_WR) && (cnt_q[2:0] == 3'h1)) begin
              sh_d = {tx_byte, 24'h000000};
              tx_take_d = 1'b1;
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      st_q <= H_IDLE;
      op_q <= '0;
      addr_q <= '0;
      wcnt_q <= '0;
      rcnt_q <= '0;
      sh_q <= '0;
      ln_q <= LN1;
      cnt_q <= '0;
      half_q <= '0;
      sclk_q <= 1'b0;
      csn_q <= 1'b1;
      rx_sh_q <= '0;
      rx_byte_q <= '0;
      rbits_q <= '0;
      rx_valid_q <= 1'b0;
      tx_take_q <= 1'b0;
    end else begin
      st_q <= st_d;
      op_q <= op_d;
      addr_q <= addr_d;
      wcnt_q <= wcnt_d;
      rcnt_q <= rcnt_d;
      sh_q <= sh_d;
      ln_q <= ln_d;
      cnt_q <= cnt_d;
      half_q <= half_d;
      sclk_q <= sclk_d;
      csn_q <= csn_d;
      rx_sh_q <= rx_sh_d;
      rx_byte_q <= rx_byte_d;
      rbits_q <= rbits_d;
      rx_valid_q <= rx_valid_d;
      tx_take_q <= tx_take_d;
    end
  end

  // pins and user side
  assign spi.cs_n = csn_q;
  assign spi.sclk = sclk_q;
  assign spi.h_out = (ln_q == LN4) ? sh_q[31:28] :
                     (ln_q == LN2) ? {2'h0, sh_q[31:30]} : {3'h0, sh_q[31]};
  assign spi.h_oe = drive ? oe_mask : 4'h0;
  assign tx_take = tx_take_q;
  assign rx_byte = rx_byte_q;
  assign rx_valid = rx_valid_q;
  assign ready = (st_q == H_IDLE);
endmodule

// ===== bench/sfoc_link_checker.sv
`timescale 1ns/1ps
module sfoc_link_checker
  import sfoc_pkg::*;
(
  input wire logic clock,
  input wire logic reset,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic [3:0] h_out,
  input wire logic [3:0] h_oe,
  input wire logic [3:0] d_out,
  input wire logic [3:0] d_oe
);
  default clocking link_cb @(posedge clock);
  endclocking
  default disable iff (reset);

  ////////////////////////////////////////////////////////////////////////
  // serial clock framing and idle levels
  idle_clock_low_a: assert property (cs_n |-> !sclk)
    else $error("serial clock high outside a frame");
  clock_high_two_a: assert property ($rose(sclk) |=> sclk ##1 !sclk)
    else $error("serial clock high phase not two cycles");
  idle_dev_off_a: assert property (cs_n && $past(cs_n) |-> d_oe == 4'h0)
    else $error("device drives lines while deselected");
  idle_host_off_a: assert property (cs_n && $past(cs_n) |-> h_oe == 4'h0)
    else $error("host drives lines while deselected");

  ////////////////////////////////////////////////////////////////////////
  // data launch and hold around the clock edges
  opcode_single_a: assert property ($fell(cs_n) |-> h_oe == OE_SI)
    else $error("opcode not on the single input line");
  opcode_quiet_a: assert property ($fell(cs_n) |-> d_oe == 4'h0 [*8])
    else $error("device drives during the opcode");
  host_data_hold_a: assert property (sclk && $past(sclk) |-> $stable(h_out))
    else $error("host data moved while clock high");
  dev_data_hold_a: assert property (sclk && $past(sclk) && !cs_n |-> $stable(d_out))
    else $error("device data moved while clock high");
  no_fight_a: assert property ((d_oe & h_oe) == 4'h0)
    else $error("host and device drive one line");

  // main transfer kinds
  cover property (d_oe == OE_SO);
  cover property (d_oe == OE_DUAL);
  cover property (d_oe == OE_QUAD);
  cover property ($rose(cs_n));
endmodule

// ===== bench/tb_serial_flash_id_and_otp_commands.sv
`timescale 1ns/1ps
module tb_serial_flash_id_and_otp_commands
  import sfoc_pkg::*;
;
  localparam logic [7:0] M_ID = 8'h3a; // arbitrary value
  localparam logic [7:0] D_ID = 8'h71; // arbitrary value
  localparam logic [7:0] M_TYPE = 8'h26; // arbitrary value
  localparam logic [7:0] M_CAP = 8'h17; // arbitrary value
  localparam logic [63:0] UID = 64'h8d2e_41b7_05c9_f36a; // arbitrary value
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic start = 1'b0;
  logic wel_set = 1'b0;
  logic [3:1] lock_set = 3'h0;
  logic [7:0] opcode = 8'h00;
  logic [7:0] tx_byte = 8'h00;
  logic [23:0] address = 24'h000000;
  logic [8:0] write_count = 9'h000;
  logic [8:0] read_count = 9'h000;
  logic tx_take, rx_valid, ready, busy, write_enable_latch;
  logic [7:0] rx_byte;
  logic [3:1] area_lock_bits;
  int failures = 0;
  int checked = 0;
  int cycles = 0;
  int busy_seen = 0;
  logic [7:0] rxq[$];

  sfoc_spi_if spi_bus();

  // 250 MHz clock
  always #2 clock = ~clock;

  sfoc_flash_dev #(.MANUF_ID(M_ID), .DEVICE_ID(D_ID), .MEM_TYPE(M_TYPE), .CAPACITY(M_CAP),
    .UNIQUE_ID(UID)) u_sfoc_flash_dev (.clock(clock), .reset(reset), .spi(spi_bus),
    .wel_set(wel_set), .lock_set(lock_set), .busy(busy),
    .write_enable_latch(write_enable_latch), .area_lock_bits(area_lock_bits));

  sfoc_spi_host u_sfoc_spi_host (.clock(clock), .reset(reset), .spi(spi_bus), .start(start),
    .opcode(opcode), .address(address), .write_count(write_count), .read_count(read_count),
    .tx_byte(tx_byte), .tx_take(tx_take), .rx_byte(rx_byte), .rx_valid(rx_valid),
    .ready(ready));

  sfoc_link_checker u_sfoc_link_checker (.clock(clock), .reset(reset), .cs_n(spi_bus.cs_n),
    .sclk(spi_bus.sclk), .h_out(spi_bus.h_out), .h_oe(spi_bus.h_oe),
    .d_out(spi_bus.d_out), .d_oe(spi_bus.d_oe));

  ////////////////////////////////////////////////////////////////////////
  // read capture, fresh random write data, hang guard
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (busy === 1'b1) busy_seen <= busy_seen + 1;
    if (rx_valid === 1'b1) rxq.push_back(rx_byte);
    if (tx_take === 1'b1) tx_byte <= 8'($urandom);
    if (cycles == 40000) begin
      failures = failures + 1;
      give_verdict();
    end
  end

  // expected byte n of a read frame
  function automatic logic [7:0] exp_byte(input logic [7:0] op, input logic [23:0] a,
      input int n);
    logic [7:0] b;
    b = a[7:0] + 8'(n);
    case (op)
      OP_UID: return UID[63 - 8 * (n % 8) -: 8];
      OP_JID: return (n == 0) ? M_ID : ((n == 1) ? M_TYPE : ((n == 2) ? M_CAP : 8'h00));
      OP_SFDP: begin
        if (a[23:8] != 16'h0000 || b > 8'h03) return 8'hff;
        return TBL_SIGNATURE[31 - 8 * b -: 8];
      end
      default: return (n[0] == a[0]) ? M_ID : D_ID;
    endcase
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checked = checked + 1;
    if (got !== exp) begin
      failures = failures + 1;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // one host frame from start to ready again
  task automatic frame(input logic [7:0] op, input logic [23:0] a, input int wc, input int rc);
    rxq.delete();
    while (ready !== 1'b1) @(posedge clock);
    start <= 1'b1;
    opcode <= op;
    address <= a;
    write_count <= 9'(wc);
    read_count <= 9'(rc);
    @(posedge clock);
    start <= 1'b0;
    @(posedge clock);
    while (ready !== 1'b1) @(posedge clock);
  endtask

  task automatic rd(input logic [7:0] op, input logic [23:0] a, input int n);
    frame(op, a, 0, n);
    chk(16'(rxq.size()), 16'(n), "read byte count");
    for (int i = 0; i < n; i++) begin
      chk(16'(rxq[i]), 16'(exp_byte(op, a, i)), "read byte");
    end
  endtask

  // protected-area command, then busy span and latch
  task automatic otp(input logic [7:0] op, input logic [23:0] a, input int wc,
      input logic exp_busy, input logic exp_wel);
    int hi;
    // busy may rise before the frame task returns, so count over the whole span
    hi = busy_seen;
    frame(op, a, wc, 0);
    repeat (300) @(posedge clock);
    chk(16'(busy_seen - hi), exp_busy ? 16'(OTP_LAST) + 16'h0001 : 16'h0000,
        "busy cycles");
    chk(16'(write_enable_latch), 16'(exp_wel), "write enable latch");
  endtask

  task automatic set_wel;
    @(posedge clock);
    wel_set <= 1'b1;
    @(posedge clock);
    wel_set <= 1'b0;
  endtask

  task automatic give_verdict;
    if (failures == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    void'($urandom(32'h9e81481c));
    repeat (5) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    // id reads in every lane mode, both byte orders, random lengths
    for (int k = 0; k < 6; k++) begin
      rd((k < 2) ? OP_ID1 : ((k < 4) ? OP_ID2 : OP_ID4), {23'h0, k[0]},
         2 + $urandom % 9);
    end
    rd(OP_UID, 24'h000000, 12);
    rd(OP_JID, 24'h000000, 4);
    rd(OP_SFDP, {16'h0000, 8'($urandom % 6)}, 5);
    rd(OP_SFDP, 24'h0000fe, 8);
    rd(OP_SFDP, 24'h010000, 4);
    // refused erases
    otp(OP_ERASE, 24'h001000, 0, 1'b0, 1'b0);
    set_wel();
    otp(OP_ERASE, 24'h004000, 0, 1'b0, 1'b1);
    otp(OP_ERASE, 24'h011000, 0, 1'b0, 1'b1);
    otp(OP_ERASE, 24'h001000, 1, 1'b0, 1'b1);
    // erase every area with a random low byte
    for (int k = 1; k < 4; k++) begin
      set_wel();
      otp(OP_ERASE, {8'h00, 4'(k), 4'h0, 8'($urandom)}, 0, 1'b1, 1'b0);
    end
    // lock area two and see its erase and program refused, then program area one, then area three without the latch
    lock_set <= 3'b010;
    set_wel();
    chk(16'(area_lock_bits), 16'h0002, "lock bits");
    otp(OP_ERASE, 24'h002000, 0, 1'b0, 1'b1);
    otp(OP_PROG, 24'h0020aa, 3, 1'b0, 1'b1);
    otp(OP_PROG, {16'h0010, 8'($urandom)}, 1 + $urandom % 4, 1'b1, 1'b0);
    otp(OP_PROG, 24'h003000, 2, 1'b0, 1'b0);
    // device still answers after the protected-area traffic
    rd(OP_ID1, 24'h000001, 3);
    give_verdict();
  end
endmodule
